//--- shared/css_pkg.sv
// constants for the core status register block
package css_pkg;
   // special-function byte addresses
   localparam logic [7:0] CSS_ADDR_STATUS = 8'hD0;
   localparam logic [7:0] CSS_ADDR_RESULT = 8'hE0;
   localparam logic [7:0] CSS_ADDR_AUX = 8'hF0;
   // bit address space: upper half maps onto bit-addressable sfrs
   localparam logic [7:0] CSS_BIT_SFR_BASE = 8'h80;
   localparam logic [7:0] CSS_BIT_BYTE_MASK = 8'hF8;
   // reset values
   localparam logic [7:0] CSS_RESULT_RST = 8'h00;
   localparam logic [7:0] CSS_AUX_RST = 8'h00;
   localparam logic [7:0] CSS_STATUS_RST = 8'h00;
   localparam logic [7:0] CSS_ZERO = 8'h00;
   localparam logic [7:0] CSS_ONES = 8'hFF;
   localparam logic [7:0] CSS_ONE_HOT0 = 8'h01;
   // status word field positions
   localparam int CSS_CARRY_BIT = 7;
   localparam int CSS_HALF_CARRY_BIT = 6;
   localparam int CSS_USER_ZERO_BIT = 5;
   localparam int CSS_BANK_HI = 4;
   localparam int CSS_BANK_LO = 3;
   localparam int CSS_WRAP_BIT = 2;
   localparam int CSS_USER_ONE_BIT = 1;
   localparam int CSS_PARITY_BIT = 0;
   // working register bank store
   localparam int CSS_WREG_AW = 5;
   localparam int CSS_WREG_DEPTH = 32;
   typedef logic [7:0] css_byte_t;
endpackage

//--- shared/css_bank_if.sv
// carrier between status block and working register store
`timescale 1ns/1ps
interface css_bank_if;
   logic [4:0] addr;
   logic we;
   logic [7:0] wdata;
   logic re;
   logic [7:0] rdata;
   modport ctrl (output addr, output we, output wdata, output re,
      input rdata);
   modport mem (input addr, input we, input wdata, input re,
      output rdata);
endinterface

//--- hw/css_wreg_mem.sv
// working register store, four banks of eight bytes
`timescale 1ns/1ps
module css_wreg_mem (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // access from the status block
   css_bank_if.mem bus
);
   import css_pkg::*;

   css_byte_t mem_q [CSS_WREG_DEPTH];
   css_byte_t rdata_ff;

   // storage array, no reset on the data
   always_ff @(posedge clk) begin
      if (bus.we) begin
         mem_q[bus.addr] <= bus.wdata;
      end
   end

   // registered read port
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata_ff <= CSS_ZERO;
      end else if (bus.re) begin
         rdata_ff <= mem_q[bus.addr];
      end
   end

   assign bus.rdata = rdata_ff;
endmodule

//--- hw/css_core_regs.sv
// core status registers: result, aux operand, status word, banks
`timescale 1ns/1ps
// Overview of operation
// - Sfrs at addresses ending in 0 or 8 also accept bit set, clear, test.
// - The result register at 0xE0 is 8-bit read/write and resets to zero.
// - Arithmetic results update carry, half-carry, overflow and parity.
// - The aux operand register at 0xF0 is 8-bit read/write, reset zero.
// - Bit 7 carry is set on carry-out, borrow or a one rotated out.
// - Bit 6 half-carry is set on a carry out of result bit 3.
// - Bits 5 and 1 are user flags that hardware never changes.
// - Bits 4:3 pick the working bank at bytes 00-07, 08-0F, 10-17, 18-1F.
// - Bit 2 overflow is set when arithmetic overflows the result.
// - Bit 0 is read-only parity of the result register, one for an odd count of ones.
// - Each bank holds eight registers on consecutive bytes.
module css_core_regs (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // byte access to special-function registers
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire css_pkg::css_byte_t sfr_wdata,
   input wire logic sfr_rd,
   output css_pkg::css_byte_t sfr_rdata,
   // single-bit access
   input wire logic [7:0] bit_addr,
   input wire logic bit_set,
   input wire logic bit_clr,
   input wire logic bit_test,
   output logic bit_rdata,
   // arithmetic unit results
   input wire logic alu_result_we,
   input wire css_pkg::css_byte_t alu_result,
   input wire logic alu_aux_we,
   input wire css_pkg::css_byte_t alu_aux,
   input wire logic alu_carry_we,
   input wire logic alu_carry,
   input wire logic alu_half_carry_we,
   input wire logic alu_half_carry,
   input wire logic alu_wrap_we,
   input wire logic alu_wrap,
   // working register access
   input wire logic [2:0] wreg_idx,
   input wire logic wreg_wr,
   input wire css_pkg::css_byte_t wreg_wdata,
   input wire logic wreg_rd,
   output css_pkg::css_byte_t wreg_rdata,
   // state towards the core
   output css_pkg::css_byte_t result_q,
   output css_pkg::css_byte_t aux_q,
   output css_pkg::css_byte_t status_q,
   output logic [1:0] bank_select,
   output logic parity_flag
);
   import css_pkg::*;

   // architectural registers
   css_byte_t result_ff;
   css_byte_t aux_ff;
   css_byte_t status_ff;

   // next values of the architectural registers
   css_byte_t nxt_result;
   css_byte_t nxt_aux;
   css_byte_t nxt_status;

   // registered read data and their next values
   css_byte_t sfr_rdata_ff;
   css_byte_t nxt_sfr_rdata;
   logic bit_rdata_ff;
   logic nxt_bit_rdata;

   // carrier towards the working register store
   css_bank_if bank_bus ();

   // bit address decode: only upper half reaches sfrs
   wire bit_in_sfr = bit_addr >= CSS_BIT_SFR_BASE;
   wire [7:0] bit_byte = bit_addr & CSS_BIT_BYTE_MASK;
   wire [2:0] bit_pos = bit_addr[2:0];
   wire bit_wr = bit_in_sfr & (bit_set | bit_clr);
   wire [7:0] bit_mask = CSS_ONE_HOT0 << bit_pos;
   wire [7:0] bit_data = bit_set ? CSS_ONES : CSS_ZERO;

   // shared write port: byte write or bit write, byte wins
   wire [7:0] wr_addr = sfr_wr ? sfr_addr : bit_byte;
   wire [7:0] wr_mask = sfr_wr ? CSS_ONES : bit_mask;
   wire [7:0] wr_data = sfr_wr ? sfr_wdata : bit_data;
   wire wr_any = sfr_wr | bit_wr;
   // unmapped addresses simply match nothing
   wire wr_result = wr_any & (wr_addr == CSS_ADDR_RESULT);
   wire wr_aux = wr_any & (wr_addr == CSS_ADDR_AUX);
   wire wr_status = wr_any & (wr_addr == CSS_ADDR_STATUS);

   // masked merge of a software write into each register
   wire [7:0] result_sw = (result_ff & ~wr_mask) | (wr_data & wr_mask);
   wire [7:0] aux_sw = (aux_ff & ~wr_mask) | (wr_data & wr_mask);
   wire [7:0] status_sw = (status_ff & ~wr_mask) | (wr_data & wr_mask);

   // live parity of the result register, never stored
   wire parity = ^result_ff;
   wire [7:0] status_view = {status_ff[7:1], parity};

   // result register: arithmetic write over software write
   always_comb begin
      nxt_result = result_ff;
      if (wr_result) begin
         nxt_result = result_sw;
      end
      if (alu_result_we) begin
         nxt_result = alu_result;
      end
   end

   // aux operand register: multiply and divide results win
   always_comb begin
      nxt_aux = aux_ff;
      if (wr_aux) begin
         nxt_aux = aux_sw;
      end
      if (alu_aux_we) begin
         nxt_aux = alu_aux;
      end
   end

   // status word: software write first, hardware flags win after
   always_comb begin
      nxt_status = status_ff;
      if (wr_status) begin
         nxt_status = status_sw;
      end
      if (alu_carry_we) begin
         nxt_status[CSS_CARRY_BIT] = alu_carry;
      end
      if (alu_half_carry_we) begin
         nxt_status[CSS_HALF_CARRY_BIT] = alu_half_carry;
      end
      if (alu_wrap_we) begin
         nxt_status[CSS_WRAP_BIT] = alu_wrap;
      end
      // stored parity slot unused, bits 5 and 1 left to software
      nxt_status[CSS_PARITY_BIT] = 1'b0;
   end

   // byte read mux, zero for anything not held here
   always_comb begin
      unique case (sfr_addr)
         CSS_ADDR_RESULT: nxt_sfr_rdata = result_ff;
         CSS_ADDR_AUX: nxt_sfr_rdata = aux_ff;
         CSS_ADDR_STATUS: nxt_sfr_rdata = status_view;
         default: nxt_sfr_rdata = CSS_ZERO;
      endcase
   end

   // bit test mux, lower bit addresses belong to ram elsewhere
   always_comb begin
      nxt_bit_rdata = 1'b0;
      if (bit_in_sfr) begin
         unique case (bit_byte)
            CSS_ADDR_RESULT: nxt_bit_rdata = result_ff[bit_pos];
            CSS_ADDR_AUX: nxt_bit_rdata = aux_ff[bit_pos];
            CSS_ADDR_STATUS: nxt_bit_rdata = status_view[bit_pos];
            default: nxt_bit_rdata = 1'b0;
         endcase
      end
   end

   // core registers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         result_ff <= CSS_RESULT_RST;
         aux_ff <= CSS_AUX_RST;
         status_ff <= CSS_STATUS_RST;
      end else begin
         result_ff <= nxt_result;
         aux_ff <= nxt_aux;
         status_ff <= nxt_status;
      end
   end

   // read data registers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sfr_rdata_ff <= CSS_ZERO;
         bit_rdata_ff <= 1'b0;
      end else begin
         if (sfr_rd) begin
            sfr_rdata_ff <= nxt_sfr_rdata;
         end
         if (bit_test) begin
            bit_rdata_ff <= nxt_bit_rdata;
         end
      end
   end

   // bank select forms the upper store address bits
   wire [1:0] bank_field = status_ff[CSS_BANK_HI:CSS_BANK_LO];
   assign bank_bus.addr = {bank_field, wreg_idx};
   assign bank_bus.we = wreg_wr;
   assign bank_bus.wdata = wreg_wdata;
   assign bank_bus.re = wreg_rd;

   // four banks of eight bytes, contents kept over reset
   css_wreg_mem css_wreg_mem_inst (
      .clk (clk),
      .nrst (nrst),
      .bus (bank_bus.mem)
   );

   // read data outputs
   assign sfr_rdata = sfr_rdata_ff;
   assign bit_rdata = bit_rdata_ff;
   assign wreg_rdata = bank_bus.rdata;

   // register state outputs
   assign result_q = result_ff;
   assign aux_q = aux_ff;
   assign status_q = status_view;
   assign bank_select = bank_field;
   assign parity_flag = parity;
endmodule

//--- tb/css_core_regs_asserts.sv
// port checker for the core status register block
`timescale 1ns/1ps
module css_core_regs_chk (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // register access
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire css_pkg::css_byte_t sfr_wdata,
   input wire logic sfr_rd,
   input wire css_pkg::css_byte_t sfr_rdata,
   input wire logic [7:0] bit_addr,
   input wire logic bit_set,
   input wire logic bit_clr,
   // arithmetic results
   input wire logic alu_result_we,
   input wire css_pkg::css_byte_t alu_result,
   input wire logic alu_carry_we,
   input wire logic alu_carry,
   input wire logic alu_half_carry_we,
   input wire logic alu_half_carry,
   input wire logic alu_wrap_we,
   input wire logic alu_wrap,
   // state
   input wire css_pkg::css_byte_t result_q,
   input wire css_pkg::css_byte_t status_q,
   input wire logic [1:0] bank_select,
   input wire logic parity_flag
);
   import css_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // live fields, then writes and their effects
   a_parity_live:
      assert property (parity_flag == ^result_q && status_q[0] == parity_flag)
      else $error("parity does not follow result register");
   a_bank_field:
      assert property (bank_select == status_q[4:3])
      else $error("bank select differs from status word");
   a_result_write:
      assert property (sfr_wr && sfr_addr == 8'he0 && !alu_result_we
         |=> result_q == $past(sfr_wdata)) else $error("result write lost");
   a_alu_result:
      assert property (alu_result_we |=> result_q == $past(alu_result))
      else $error("arithmetic result not stored");
   a_carry_update:
      assert property (alu_carry_we |=> status_q[7] == $past(alu_carry))
      else $error("carry flag not updated");
   a_half_update:
      assert property (alu_half_carry_we
         |=> status_q[6] == $past(alu_half_carry))
      else $error("half carry flag not updated");
   a_wrap_update:
      assert property (alu_wrap_we |=> status_q[2] == $past(alu_wrap))
      else $error("overflow flag not updated");
   a_user_hold:
      assert property (!(sfr_wr && sfr_addr == 8'hd0) && !bit_set && !bit_clr
         |=> $stable({status_q[5], status_q[1]})) else $error("user flag moved");
   a_unmapped_read:
      assert property (sfr_rd && sfr_addr == 8'h81 |=> sfr_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_bit_set:
      assert property (bit_set && bit_addr == 8'hd5 && !sfr_wr |=> status_q[5])
      else $error("bit set on status word lost");
   a_status_read:
      assert property (sfr_rd && sfr_addr == 8'hd0
         |=> sfr_rdata == $past(status_q))
      else $error("status read differs");
endmodule
bind css_core_regs css_core_regs_chk css_core_regs_chk_inst (.clk, .nrst,
   .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd, .sfr_rdata, .bit_addr, .bit_set,
   .bit_clr, .alu_result_we, .alu_result, .alu_carry_we, .alu_carry,
   .alu_half_carry_we, .alu_half_carry, .alu_wrap_we, .alu_wrap, .result_q,
   .status_q, .bank_select, .parity_flag);

//--- tb/testbench.sv
// self-checking bench for the core status register block
`timescale 1ns/1ps
module testbench;
   import css_pkg::*;
   logic clk = 0, nrst = 0, sfr_wr = 0, sfr_rd = 0, bit_set = 0, bit_clr = 0;
   logic bit_test = 0, wreg_wr = 0, wreg_rd = 0, alu_result_we = 0;
   logic alu_aux_we = 0, alu_carry_we = 0, alu_half_carry_we = 0;
   logic alu_wrap_we = 0, alu_carry = 0, alu_half_carry = 0, alu_wrap = 0;
   logic bit_rdata, parity_flag;
   logic [7:0] sfr_addr = '0, bit_addr = '0;
   logic [2:0] wreg_idx = '0;
   logic [1:0] bank_select;
   css_byte_t sfr_wdata = '0, alu_result = '0, alu_aux = '0, wreg_wdata = '0;
   css_byte_t sfr_rdata, wreg_rdata, result_q, aux_q, status_q;
   int mismatches = 0, checked = 0, cycles = 0;
   css_core_regs css_core_regs_inst (.clk, .nrst, .sfr_addr, .sfr_wr,
      .sfr_wdata, .sfr_rd, .sfr_rdata, .bit_addr, .bit_set, .bit_clr,
      .bit_test, .bit_rdata, .alu_result_we, .alu_result, .alu_aux_we,
      .alu_aux, .alu_carry_we, .alu_carry, .alu_half_carry_we,
      .alu_half_carry, .alu_wrap_we, .alu_wrap, .wreg_idx, .wreg_wr,
      .wreg_wdata, .wreg_rd, .wreg_rdata, .result_q, .aux_q, .status_q,
      .bank_select, .parity_flag);
   // clock and hang guard
   always #20 clk = ~clk;
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 1000) begin
         mismatches++;
         end_sim();
      end
   end
   task automatic end_sim();
      if (mismatches == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic cmp(string name, css_byte_t exp, css_byte_t got);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   // access tasks, each strobe held for one edge
   task automatic wr(logic [7:0] a, css_byte_t d);
      @(posedge clk);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1;
      @(posedge clk);
      sfr_wr <= 0;
   endtask
   task automatic rd(logic [7:0] a, css_byte_t e);
      @(posedge clk);
      sfr_addr <= a;
      sfr_rd <= 1;
      @(posedge clk);
      sfr_rd <= 0;
      #1 cmp("sfr_rdata", e, sfr_rdata);
   endtask
   task automatic bitop(logic s, logic c, logic t, logic [7:0] a);
      @(posedge clk);
      bit_addr <= a;
      {bit_set, bit_clr, bit_test} <= {s, c, t};
      @(posedge clk);
      {bit_set, bit_clr, bit_test} <= 3'h0;
      #1;
   endtask
   task automatic alu(css_byte_t a, css_byte_t b, logic [2:0] fl);
      @(posedge clk);
      {alu_result, alu_aux, alu_carry, alu_half_carry, alu_wrap} <= {a, b, fl};
      {alu_result_we, alu_aux_we, alu_carry_we} <= 3'h7;
      {alu_half_carry_we, alu_wrap_we} <= 2'h3;
      @(posedge clk);
      {alu_result_we, alu_aux_we, alu_carry_we} <= 3'h0;
      {alu_half_carry_we, alu_wrap_we} <= 2'h0;
      #1;
   endtask
   task automatic wreg(logic w, logic [2:0] i, css_byte_t d);
      @(posedge clk);
      {wreg_idx, wreg_wdata, wreg_wr, wreg_rd} <= {i, d, w, !w};
      @(posedge clk);
      {wreg_wr, wreg_rd} <= 2'h0;
      #1;
   endtask
   // main sequence
   initial begin
      repeat (16) @(posedge clk);
      nrst <= 1;
      rd(8'he0, 8'h00);
      rd(8'hf0, 8'h00);
      rd(8'hd0, 8'h00);
      wr(8'he0, 8'h03);
      cmp("parity_flag", 8'h00, {7'h00, parity_flag});
      wr(8'hd0, 8'hff);
      rd(8'hd0, 8'hfe);
      cmp("bank_select", 8'h03, {6'h00, bank_select});
      wr(8'hf0, 8'ha5);
      rd(8'hf0, 8'ha5);
      wr(8'h81, 8'h5a);
      rd(8'h81, 8'h00);
      alu(8'h01, 8'h3c, 3'h0);
      cmp("status_q", 8'h3b, status_q);
      cmp("parity_flag", 8'h01, {7'h00, parity_flag});
      cmp("aux_q", 8'h3c, aux_q);
      alu(8'h80, 8'h3c, 3'h7);
      cmp("status_q", 8'hff, status_q);
      cmp("result_q", 8'h80, result_q);
      bitop(0, 1, 0, 8'hd5);
      cmp("status_q", 8'hdf, status_q);
      bitop(1, 0, 1, 8'hd5);
      cmp("bit_rdata", 8'h00, {7'h00, bit_rdata});
      cmp("status_q", 8'hff, status_q);
      bitop(0, 0, 1, 8'he7);
      cmp("bit_rdata", 8'h01, {7'h00, bit_rdata});
      bitop(1, 0, 0, 8'hf0);
      cmp("aux_q", 8'h3d, aux_q);
      bitop(0, 1, 1, 8'h07);
      cmp("bit_rdata", 8'h00, {7'h00, bit_rdata});
      cmp("status_q", 8'hff, status_q);
      for (int k = 0; k < 4; k++) begin
         wr(8'hd0, 8'(k * 8));
         wreg(1, 3'h7, 8'(8'ha0 + k));
      end
      for (int k = 0; k < 4; k++) begin
         wr(8'hd0, 8'(k * 8));
         wreg(0, 3'h7, 8'h00);
         cmp("wreg_rdata", 8'(8'ha0 + k), wreg_rdata);
      end
      end_sim();
   end
endmodule
